// ==== rtl/qdec_pkg.sv ====
// Purpose: shared constants for the encoder position decoder
// Assumes: 200 MHz system clock
// Notes: counts and timing figures live here only
package qdec_pkg;
	localparam int POS_W = 32;
	localparam logic [POS_W-1:0] POS_RESET = 32'h0000_0000;
	localparam int CLK_HZ = 200_000_000;
	localparam int MAX_CYCLE_HZ = 5_500_000;
	localparam int MAX_COUNT_HZ = 22_000_000;
	// system clocks per quadrature count at the highest legal input rate (rounded down)
	localparam int CLKS_PER_COUNT = CLK_HZ / MAX_COUNT_HZ;
	// two synchroniser stages plus one decode stage must fit inside one count period
	localparam int SYNC_STAGES = 2;
	typedef enum logic [0:0] {
		FB_QUADRATURE,
		FB_PULSE_DIR
	} fb_mode_t;
	localparam fb_mode_t FB_MODE_RESET = FB_QUADRATURE;
endpackage : qdec_pkg

// ==== rtl/quadrature_encoder_decoder.sv ====
// Purpose: one axis of incremental encoder position feedback
// Assumes: encoder pins asynchronous to CLK_SYS_I; mode input synchronous
// Notes: position counter wraps at its width
// Functional notes
// - Count every quadrature state change: four counts per encoder cycle; a change on both channels at once sets ILLEGAL_O and is not counted.
// - Optional index channel is passed on as a position sync reference.
// - Per-axis setting selects pulse/direction input instead of quadrature.
// - Input stays at or below 5.5M cycles/s; decoder counts correctly there.
// - After reset the axis decodes standard quadrature until configured otherwise.
module quadrature_encoder_decoder
	import qdec_pkg::*;
(
	// clock and reset
	input wire logic CLK_SYS_I,
	input wire logic RST_N_I,
	// configuration
	input wire qdec_pkg::fb_mode_t FB_MODE_I,
	input wire logic POS_CLEAR_I,
	// encoder pins
	input wire logic ENCODER_CHANNEL_A_I,
	input wire logic ENCODER_CHANNEL_B_I,
	input wire logic ENCODER_INDEX_I,
	// position results
	output logic [qdec_pkg::POS_W-1:0] POSITION_O,
	output logic COUNT_UP_O,
	output logic COUNT_DOWN_O,
	output logic ILLEGAL_O,
	output logic INDEX_O,
	output logic INDEX_RISE_O,
	output logic [qdec_pkg::POS_W-1:0] INDEX_POS_O
);
	import qdec_pkg::*;

	logic [SYNC_STAGES-1:0] a_sync_ff;
	logic [SYNC_STAGES-1:0] b_sync_ff;
	logic [SYNC_STAGES-1:0] i_sync_ff;
	logic a_prev_ff;
	logic b_prev_ff;
	logic i_prev_ff;
	fb_mode_t mode_ff;
	logic [POS_W-1:0] pos_ff;
	logic [POS_W-1:0] nxt_pos;
	logic up_ff;
	logic down_ff;
	logic illegal_ff;
	logic index_rise_ff;
	logic [POS_W-1:0] index_pos_ff;
	logic a_now;
	logic b_now;
	logic inc;
	logic dec;
	logic bad;

	// two-stage synchronisers; only the last stage feeds logic
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			a_sync_ff <= '0;
			b_sync_ff <= '0;
			i_sync_ff <= '0;
		end else begin
			a_sync_ff <= {a_sync_ff[SYNC_STAGES-2:0], ENCODER_CHANNEL_A_I};
			b_sync_ff <= {b_sync_ff[SYNC_STAGES-2:0], ENCODER_CHANNEL_B_I};
			i_sync_ff <= {i_sync_ff[SYNC_STAGES-2:0], ENCODER_INDEX_I};
		end
	end

	assign a_now = a_sync_ff[SYNC_STAGES-1];
	assign b_now = b_sync_ff[SYNC_STAGES-1];

	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			a_prev_ff <= 1'b0;
			b_prev_ff <= 1'b0;
			i_prev_ff <= 1'b0;
		end else begin
			a_prev_ff <= a_now;
			b_prev_ff <= b_now;
			i_prev_ff <= i_sync_ff[SYNC_STAGES-1];
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			mode_ff <= FB_MODE_RESET;
		end else begin
			mode_ff <= FB_MODE_I;
		end
	end

	// count decision; one state step per clock is enough since a count lasts 9 clocks
	always_comb begin
		inc = 1'b0;
		dec = 1'b0;
		bad = 1'b0;
		case (mode_ff)
			FB_QUADRATURE: begin
				if ((a_now ^ a_prev_ff) && (b_now ^ b_prev_ff)) begin
					bad = 1'b1;
				end else if (a_now ^ a_prev_ff) begin
					// A moved: up when A now differs from B (A leads)
					inc = a_now ^ b_now;
					dec = ~(a_now ^ b_now);
				end else if (b_now ^ b_prev_ff) begin
					inc = ~(a_now ^ b_now);
					dec = a_now ^ b_now;
				end
			end
			FB_PULSE_DIR: begin
				// A is the pulse line, B gives direction (high counts up)
				if (a_now && !a_prev_ff) begin
					inc = b_now;
					dec = ~b_now;
				end
			end
			default: begin
				bad = 1'b0;
			end
		endcase
	end

	always_comb begin
		nxt_pos = pos_ff;
		if (POS_CLEAR_I) begin
			nxt_pos = POS_RESET;
		end else if (inc) begin
			nxt_pos = pos_ff + 32'h0000_0001;
		end else if (dec) begin
			nxt_pos = pos_ff - 32'h0000_0001;
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			pos_ff <= POS_RESET;
			up_ff <= 1'b0;
			down_ff <= 1'b0;
			illegal_ff <= 1'b0;
		end else begin
			pos_ff <= nxt_pos;
			up_ff <= inc;
			down_ff <= dec;
			illegal_ff <= bad;
		end
	end

	// index edge latches position for synchronisation
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			index_rise_ff <= 1'b0;
			index_pos_ff <= POS_RESET;
		end else begin
			index_rise_ff <= i_sync_ff[SYNC_STAGES-1] & ~i_prev_ff;
			if (i_sync_ff[SYNC_STAGES-1] && !i_prev_ff) begin
				index_pos_ff <= nxt_pos;
			end
		end
	end

	assign POSITION_O = pos_ff;
	assign COUNT_UP_O = up_ff;
	assign COUNT_DOWN_O = down_ff;
	assign ILLEGAL_O = illegal_ff;
	assign INDEX_O = i_prev_ff;
	assign INDEX_RISE_O = index_rise_ff;
	assign INDEX_POS_O = index_pos_ff;

	a_quad_up: assert property (
		@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		(mode_ff == FB_QUADRATURE && !POS_CLEAR_I && (a_now != a_prev_ff)
		&& (b_now == b_prev_ff) && (a_now != b_now))
		|=> (COUNT_UP_O && pos_ff == $past(pos_ff) + 1))
		else $error("quadrature step with A leading did not count up");
	a_quad_down: assert property (
		@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		(mode_ff == FB_QUADRATURE && !POS_CLEAR_I && (b_now != b_prev_ff)
		&& (a_now == a_prev_ff) && (a_now != b_now))
		|=> (COUNT_DOWN_O && pos_ff == $past(pos_ff) - 1))
		else $error("quadrature step with B leading did not count down");
	a_illegal_hold: assert property (
		@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		(mode_ff == FB_QUADRATURE && !POS_CLEAR_I && (a_now != a_prev_ff)
		&& (b_now != b_prev_ff)) |=> ($stable(pos_ff) && ILLEGAL_O && !COUNT_UP_O))
		else $error("illegal quadrature jump changed the count");
	a_pd_count: assert property (
		@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		(mode_ff == FB_PULSE_DIR && !POS_CLEAR_I && a_now && !a_prev_ff)
		|=> (pos_ff == (b_prev_ff ? $past(pos_ff) + 1 : $past(pos_ff) - 1)))
		else $error("pulse/direction count wrong");
	a_pd_idle: assert property (
		@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		(mode_ff == FB_PULSE_DIR && !POS_CLEAR_I && !(a_now && !a_prev_ff))
		|=> $stable(pos_ff))
		else $error("pulse/direction counted without a pulse");
	a_mode_default: assert property (
		@(posedge CLK_SYS_I)
		$rose(RST_N_I) |-> (mode_ff == FB_QUADRATURE))
		else $error("mode not quadrature after reset");
	a_index_latch: assert property (
		@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		(i_sync_ff[SYNC_STAGES-1] && !i_prev_ff)
		|=> (INDEX_RISE_O && INDEX_POS_O == POSITION_O))
		else $error("index edge did not latch position");
	a_rate_step: assert property (
		@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		!POS_CLEAR_I |=> ((pos_ff - $past(pos_ff) == 32'h0000_0001)
		|| ($past(pos_ff) - pos_ff == 32'h0000_0001) || $stable(pos_ff)))
		else $error("position moved more than one count per clock");
	a_pulse_excl: assert property (
		@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		$onehot0({COUNT_UP_O, COUNT_DOWN_O, ILLEGAL_O}))
		else $error("more than one count pulse in a cycle");
	a_pd_dir_only: assert property (
		@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		(mode_ff == FB_PULSE_DIR && !POS_CLEAR_I && (b_now != b_prev_ff) && (a_now == a_prev_ff))
		|=> ($stable(pos_ff) && !COUNT_UP_O && !COUNT_DOWN_O))
		else $error("direction change alone moved the count");
	a_pd_no_illegal: assert property (
		@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		(mode_ff == FB_PULSE_DIR) |=> !ILLEGAL_O)
		else $error("illegal jump flagged in pulse/direction mode");
	a_index_pulse: assert property (
		@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		INDEX_RISE_O |=> !INDEX_RISE_O)
		else $error("index rise pulse stood longer than one cycle");
endmodule : quadrature_encoder_decoder

// ==== tb/enc_model.sv ====
// Purpose: encoder pin model for one axis
// Assumes: every change lands 1 ns after a clock edge
// Notes: idles with all pins low
module enc_model (
	input wire logic clk_i,
	output logic a_o,
	output logic b_o,
	output logic idx_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import qdec_pkg::*;
	// the rounded-down count period is slightly too fast; one clock more keeps the rate legal
	int gap = CLKS_PER_COUNT + 1;
	initial {a_o, b_o, idx_o} = 3'h0;
	task automatic wt;
		repeat (gap) @(posedge clk_i);
		#1;
	endtask : wt
	task automatic quad(input logic up);
		logic na;
		wt();
		na = up ? ~b_o : b_o;
		b_o = up ? a_o : ~a_o;
		a_o = na;
	endtask : quad
	task automatic jump;
		wt();
		{a_o, b_o} = ~{a_o, b_o};
	endtask : jump
	task automatic pulse(input logic up);
		wt();
		b_o = up;
		wt();
		a_o = 1'b1;
		wt();
		a_o = 1'b0;
	endtask : pulse
	task automatic mark(input logic lvl);
		wt();
		idx_o = lvl;
	endtask : mark
endmodule : enc_model

// ==== tb/testbench.sv ====
// Purpose: self-checking bench for the encoder position decoder
// Assumes: model paces steps just under the top legal rate
// Notes: scenarios run in order and share the position count
module testbench import qdec_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic clr = 1'b0;
	fb_mode_t mode = FB_QUADRATURE;
	logic a, b, idx, up, dn, ill, idx_lvl, idx_rise;
	logic [3:0] seen;
	logic [POS_W-1:0] pos, idx_pos;
	int error_cnt = 0;
	int total_checks = 0;
	always #2.5 clk = ~clk;
	quadrature_encoder_decoder dut_u (
		.CLK_SYS_I(clk), .RST_N_I(rst_n), .FB_MODE_I(mode), .POS_CLEAR_I(clr),
		.ENCODER_CHANNEL_A_I(a), .ENCODER_CHANNEL_B_I(b), .ENCODER_INDEX_I(idx),
		.POSITION_O(pos), .COUNT_UP_O(up), .COUNT_DOWN_O(dn), .ILLEGAL_O(ill),
		.INDEX_O(idx_lvl), .INDEX_RISE_O(idx_rise), .INDEX_POS_O(idx_pos)
	);
	enc_model enc (.clk_i(clk), .a_o(a), .b_o(b), .idx_o(idx));
	task automatic chk(input logic [POS_W-1:0] got, input logic [POS_W-1:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic settle;
		seen = 4'h0;
		repeat (6) begin
			@(posedge clk);
			#1 seen = seen | {idx_rise, ill, dn, up};
		end
	endtask : settle
	task automatic conclude;
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : conclude
	task automatic t_quad;
		repeat (4) enc.quad(1'b1);
		settle();
		chk(pos, 32'h4);
		chk(seen, 4'h1);
		repeat (5) enc.quad(1'b0);
		settle();
		chk(pos, 32'hffff_ffff);
		chk(seen, 4'h2);
		enc.quad(1'b1);
		settle();
		chk(pos, 32'h0);
		chk(seen, 4'h1);
		$display("quadrature test done");
	endtask : t_quad
	task automatic t_jump;
		enc.jump();
		settle();
		chk(seen, 4'h4);
		chk(pos, 32'h0);
		enc.jump();
		settle();
		chk(seen, 4'h4);
		chk(pos, 32'h0);
		$display("illegal jump test done");
	endtask : t_jump
	task automatic t_pd;
		mode = FB_PULSE_DIR;
		repeat (3) enc.pulse(1'b1);
		enc.pulse(1'b0);
		settle();
		chk(pos, 32'h2);
		chk(seen, 4'h0);
		mode = FB_QUADRATURE;
		settle();
		$display("pulse direction test done");
	endtask : t_pd
	task automatic t_index;
		enc.mark(1'b1);
		settle();
		chk(idx_pos, 32'h2);
		chk(idx_lvl, 1'b1);
		chk(seen, 4'h8);
		enc.mark(1'b0);
		clr = 1'b1;
		@(posedge clk);
		#1 clr = 1'b0;
		settle();
		chk(pos, 32'h0);
		chk(idx_pos, 32'h2);
		chk(idx_lvl, 1'b0);
		$display("index and clear test done");
	endtask : t_index
	initial begin
		repeat (20) @(posedge clk);
		#1 rst_n = 1'b1;
		chk(pos, 32'h0);
		t_quad();
		t_jump();
		t_pd();
		t_index();
		conclude();
	end
	initial begin
		repeat (5000) @(posedge clk);
		error_cnt++;
		conclude();
	end
endmodule : testbench
